//--- core/lfs_pkg.sv
// Package with register map, field positions and reset values of the bank.
package lfs_pkg;
  localparam int          LFS_ADDR_W      = 8;
  localparam int          LFS_DATA_W      = 8;
  localparam logic [7:0]  LFS_OFF_EVT0    = 8'h3C;
  localparam logic [7:0]  LFS_OFF_OUT1    = 8'h40;
  localparam logic [7:0]  LFS_OFF_OUT2    = 8'h41;
  localparam logic [7:0]  LFS_OFF_EVT1    = 8'h42;
  localparam logic [7:0]  LFS_OFF_EVT2    = 8'h43;
  localparam logic [7:0]  LFS_OFF_LTCH1   = 8'h3A;
  localparam logic [7:0]  LFS_OFF_LTCH2   = 8'h3B;
  localparam logic [7:0]  LFS_RESET_VALUE = 8'h00;
  // Implemented bit masks; every other position is reserved and reads 0.
  localparam logic [7:0]  LFS_MASK_EVT0   = 8'hC0;
  localparam logic [7:0]  LFS_MASK_OUT1   = 8'hF0;
  localparam logic [7:0]  LFS_MASK_OUT2   = 8'hF1;
  localparam logic [7:0]  LFS_MASK_EVT1   = 8'h0E;
  localparam logic [7:0]  LFS_MASK_EVT2   = 8'hF0;
  localparam int          LFS_BIT_CLK_ERR = 7;
  localparam int          LFS_BIT_PLL_LCK = 6;
  localparam int          LFS_BIT_POS_SC  = 7;
  localparam int          LFS_BIT_NEG_SC  = 6;
  localparam int          LFS_BIT_POS_VG  = 5;
  localparam int          LFS_BIT_NEG_VG  = 4;
  localparam int          LFS_BIT_REG_SC  = 0;
  localparam int          LFS_BIT_INSERT  = 3;
  localparam int          LFS_BIT_REMOVE  = 2;
  localparam int          LFS_BIT_HOOK    = 1;
  localparam int          LFS_BIT_GPA_UP  = 7;
  localparam int          LFS_BIT_GPA_LO  = 6;
  localparam int          LFS_BIT_VAD_UP  = 5;
  localparam int          LFS_BIT_VAD_DN  = 4;
endpackage

//--- core/lfs_chan_fault.sv
// Packs one output channel's fault sources into its live register.
`timescale 1ns/1ps
`default_nettype none
module lfs_chan_fault
  import lfs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       pos_short,
  input  wire logic       neg_short,
  input  wire logic       pos_vground,
  input  wire logic       neg_vground,
  input  wire logic       extra_bit0,
  input  wire logic [7:0] mask,
  output logic      [7:0] live
);
  logic [7:0] next_live;

  // Bit positions are identical for both channels; only bit 0 differs.
  always_comb
  begin
    next_live                 = 8'h00;
    next_live[LFS_BIT_POS_SC] = pos_short;
    next_live[LFS_BIT_NEG_SC] = neg_short;
    next_live[LFS_BIT_POS_VG] = pos_vground;
    next_live[LFS_BIT_NEG_VG] = neg_vground;
    next_live[LFS_BIT_REG_SC] = extra_bit0;
    next_live                 = next_live & mask;
  end

  // Sampled each cycle, never held, so a cleared fault clears the bit.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      live <= LFS_RESET_VALUE;
    else
      live <= next_live;
  end
endmodule
`default_nettype wire

//--- core/lfs_latch_bit.sv
// One sticky latched copy of a source that clears when read.
`timescale 1ns/1ps
`default_nettype none
module lfs_latch_bit #(
  parameter int WIDTH = 8
)(
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] source,
  input  wire logic             rd_clear,
  output logic      [WIDTH-1:0] latched
);
  // A source that is high in the clearing cycle wins over the clear.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      latched <= '0;
    else if (rd_clear)
      latched <= source;
    else
      latched <= latched | source;
  end
endmodule
`default_nettype wire

//--- core/lfs_live_status.sv
// Live fault and event status bank with its register read port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Bit 7 at 0x3C shows clock error.
// - Bit 6 at 0x3C shows PLL lock.
// - Reserved bits read zero; host writes zero.
// - Bit 7 at 0x40: channel one positive short.
// - Bit 6 at 0x40: channel one negative short.
// - Bit 5 at 0x40: channel one positive vground.
// - Bit 4 at 0x40: channel one negative vground.
// - Bit 7 at 0x41: channel two positive short.
// - Bit 6 at 0x41: channel two negative short.
// - Bit 5 at 0x41: channel two positive vground.
// - Bit 4 at 0x41: channel two negative vground.
// - Bit 0 at 0x41: regulator short fault.
// - Bit 3 at 0x42: headset inserted.
// - Bit 2 at 0x42: headset removed.
// - Bit 1 at 0x42: hook button event.
// - Bit 7 at 0x43: analog input above threshold.
// - Bit 6 at 0x43: analog input below threshold.
// - Bit 5 at 0x43: voice power-up detect.
// - Bit 4 at 0x43: voice power-down detect.
// - Live bits follow sources, never latched.
// - Latched copies self-clear on read, independently.
module lfs_live_status
  import lfs_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  clock_error,
  input  wire logic                  pll_lock,
  input  wire logic                  chan_one_pos_short,
  input  wire logic                  chan_one_neg_short,
  input  wire logic                  chan_one_pos_vground,
  input  wire logic                  chan_one_neg_vground,
  input  wire logic                  chan_two_pos_short,
  input  wire logic                  chan_two_neg_short,
  input  wire logic                  chan_two_pos_vground,
  input  wire logic                  chan_two_neg_vground,
  input  wire logic                  regulator_short_live,
  input  wire logic                  headset_insert,
  input  wire logic                  headset_remove,
  input  wire logic                  headset_hook,
  input  wire logic                  gpa_above_upper,
  input  wire logic                  gpa_below_lower,
  input  wire logic                  vad_power_up,
  input  wire logic                  vad_power_down,
  input  wire logic                  reg_rd,
  input  wire logic                  reg_wr,
  input  wire logic [LFS_ADDR_W-1:0] reg_addr,
  input  wire logic [LFS_DATA_W-1:0] reg_wdata,
  output logic      [LFS_DATA_W-1:0] reg_rdata,
  output logic                       reg_hit
);
  import lfs_pkg::*;

  logic [7:0] live_event_status_zero;
  logic [7:0] output_one_fault_live;
  logic [7:0] output_two_fault_live;
  logic [7:0] live_event_status_one;
  logic [7:0] live_event_status_two;
  logic [7:0] next_evt0;
  logic [7:0] next_evt1;
  logic [7:0] next_evt2;
  logic [7:0] latch_one;
  logic [7:0] latch_two;
  logic [7:0] next_rdata;
  logic       next_hit;
  logic       clr_one;
  logic       clr_two;

  // Channel fault packing is shared, so it lives in one small module.
  lfs_chan_fault u_out_one (
    .clock       (clock),
    .rst_n       (rst_n),
    .pos_short   (chan_one_pos_short),
    .neg_short   (chan_one_neg_short),
    .pos_vground (chan_one_pos_vground),
    .neg_vground (chan_one_neg_vground),
    .extra_bit0  (1'b0),
    .mask        (LFS_MASK_OUT1),
    .live        (output_one_fault_live)
  );

  lfs_chan_fault u_out_two (
    .clock       (clock),
    .rst_n       (rst_n),
    .pos_short   (chan_two_pos_short),
    .neg_short   (chan_two_neg_short),
    .pos_vground (chan_two_pos_vground),
    .neg_vground (chan_two_neg_vground),
    .extra_bit0  (regulator_short_live),
    .mask        (LFS_MASK_OUT2),
    .live        (output_two_fault_live)
  );

  // Event registers are rebuilt from sources every cycle.
  always_comb
  begin
    next_evt0                  = 8'h00;
    next_evt0[LFS_BIT_CLK_ERR] = clock_error;
    next_evt0[LFS_BIT_PLL_LCK] = pll_lock;
    next_evt1                  = 8'h00;
    next_evt1[LFS_BIT_INSERT]  = headset_insert;
    next_evt1[LFS_BIT_REMOVE]  = headset_remove;
    next_evt1[LFS_BIT_HOOK]    = headset_hook;
    next_evt2                  = 8'h00;
    next_evt2[LFS_BIT_GPA_UP]  = gpa_above_upper;
    next_evt2[LFS_BIT_GPA_LO]  = gpa_below_lower;
    next_evt2[LFS_BIT_VAD_UP]  = vad_power_up;
    next_evt2[LFS_BIT_VAD_DN]  = vad_power_down;
  end

  // No write path reaches these flops, so host writes cannot disturb them.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      live_event_status_zero <= LFS_RESET_VALUE;
      live_event_status_one  <= LFS_RESET_VALUE;
      live_event_status_two  <= LFS_RESET_VALUE;
    end
    else
    begin
      live_event_status_zero <= next_evt0 & LFS_MASK_EVT0;
      live_event_status_one  <= next_evt1 & LFS_MASK_EVT1;
      live_event_status_two  <= next_evt2 & LFS_MASK_EVT2;
    end
  end

  // Latched copies feed from sources, not from the live flops.
  assign clr_one = reg_rd && (reg_addr == LFS_OFF_LTCH1);
  assign clr_two = reg_rd && (reg_addr == LFS_OFF_LTCH2);

  lfs_latch_bit #(.WIDTH(8)) u_latch_one (
    .clock    (clock),
    .rst_n    (rst_n),
    .source   (next_evt1 & LFS_MASK_EVT1),
    .rd_clear (clr_one),
    .latched  (latch_one)
  );

  lfs_latch_bit #(.WIDTH(8)) u_latch_two (
    .clock    (clock),
    .rst_n    (rst_n),
    .source   (next_evt2 & LFS_MASK_EVT2),
    .rd_clear (clr_two),
    .latched  (latch_two)
  );

  // Read decode; unmapped addresses answer zero with no hit.
  always_comb
  begin
    next_rdata = 8'h00;
    next_hit   = 1'b1;
    case (reg_addr)
      LFS_OFF_EVT0:  next_rdata = live_event_status_zero;
      LFS_OFF_OUT1:  next_rdata = output_one_fault_live;
      LFS_OFF_OUT2:  next_rdata = output_two_fault_live;
      LFS_OFF_EVT1:  next_rdata = live_event_status_one;
      LFS_OFF_EVT2:  next_rdata = live_event_status_two;
      LFS_OFF_LTCH1: next_rdata = latch_one;
      LFS_OFF_LTCH2: next_rdata = latch_two;
      default:       next_hit   = 1'b0;
    endcase
  end

  // Read data is registered; it is one cycle behind the read strobe.
  // The write data port exists for the host but is deliberately unused.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      reg_rdata <= LFS_RESET_VALUE;
      reg_hit   <= 1'b0;
    end
    else if (reg_rd)
    begin
      reg_rdata <= next_rdata;
      reg_hit   <= next_hit;
    end
    else
    begin
      reg_rdata <= LFS_RESET_VALUE;
      reg_hit   <= 1'b0;
    end
  end

  // Assertions guard the read path and the live mirroring.
  clk_err_live_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> live_event_status_zero[LFS_BIT_CLK_ERR]
      == $past(clock_error))
    else $error("clock error live bit wrong");
  pll_lock_live_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> live_event_status_zero[LFS_BIT_PLL_LCK]
      == $past(pll_lock))
    else $error("pll lock live bit wrong");
  reserved_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    ((live_event_status_zero & ~LFS_MASK_EVT0) == 8'h00) &&
    ((output_two_fault_live & ~LFS_MASK_OUT2) == 8'h00))
    else $error("reserved bit nonzero");
  out1_short_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> output_one_fault_live[7:6]
      == $past({chan_one_pos_short, chan_one_neg_short}))
    else $error("channel one short bits wrong");
  reg_short_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> output_two_fault_live[LFS_BIT_REG_SC]
      == $past(regulator_short_live))
    else $error("regulator short bit wrong");
  headset_live_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> live_event_status_one[3:1]
      == $past({headset_insert, headset_remove, headset_hook}))
    else $error("headset live bits wrong");
  vad_gpa_live_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> live_event_status_two[7:4] == $past({gpa_above_upper,
      gpa_below_lower, vad_power_up, vad_power_down}))
    else $error("analog or voice live bits wrong");
  live_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_rd && reg_addr == LFS_OFF_EVT2) |=>
      (reg_rdata == $past(live_event_status_two)) && reg_hit)
    else $error("live read data wrong");
  write_ignored_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_wr && !reg_rd && $past(rst_n)) |=> (live_event_status_one
      == ($past(next_evt1) & LFS_MASK_EVT1)))
    else $error("write disturbed live register");
  latch_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
    (headset_insert && !clr_one) |=> latch_one[LFS_BIT_INSERT])
    else $error("latched copy lost an event");
  unmapped_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_rd && reg_addr == 8'h00) |=> (!reg_hit && reg_rdata == 8'h00))
    else $error("unmapped read answered");

  read_evt0_c: cover property (@(posedge clock) disable iff (!rst_n)
    reg_rd && reg_addr == LFS_OFF_EVT0 && live_event_status_zero != 8'h00);
  read_out2_c: cover property (@(posedge clock) disable iff (!rst_n)
    reg_rd && reg_addr == LFS_OFF_OUT2 && output_two_fault_live[0]);
  clear_latch_c: cover property (@(posedge clock) disable iff (!rst_n)
    clr_two && latch_two != 8'h00);
  fault_gone_c: cover property (@(posedge clock) disable iff (!rst_n)
    output_one_fault_live[7] ##1 !output_one_fault_live[7]);
endmodule
`default_nettype wire

//--- sim/lfs_live_status_test.sv
// Self-checking bench for the live fault and event status bank.
`timescale 1ns/1ps
`default_nettype none
module lfs_live_status_test;
  import lfs_pkg::*;
  logic        clock;
  logic        rst_n;
  logic [17:0] src;
  logic [17:0] acc;
  logic        reg_rd;
  logic        reg_wr;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_hit;
  int          failures;
  int          num_checks;
  int          seed;
  int          r;
  logic [7:0]  addr_q[$];

  // Sources are one vector so tables and loops can walk them.
  lfs_live_status u_lfs_live_status (
    .clock                (clock),
    .rst_n                (rst_n),
    .clock_error          (src[0]),
    .pll_lock             (src[1]),
    .chan_one_pos_short   (src[2]),
    .chan_one_neg_short   (src[3]),
    .chan_one_pos_vground (src[4]),
    .chan_one_neg_vground (src[5]),
    .chan_two_pos_short   (src[6]),
    .chan_two_neg_short   (src[7]),
    .chan_two_pos_vground (src[8]),
    .chan_two_neg_vground (src[9]),
    .regulator_short_live (src[10]),
    .headset_insert       (src[11]),
    .headset_remove       (src[12]),
    .headset_hook         (src[13]),
    .gpa_above_upper      (src[14]),
    .gpa_below_lower      (src[15]),
    .vad_power_up         (src[16]),
    .vad_power_down       (src[17]),
    .reg_rd               (reg_rd),
    .reg_wr               (reg_wr),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_rdata            (reg_rdata),
    .reg_hit              (reg_hit)
  );

  // Free-running clock at 20 MHz.
  always #25 clock = ~clock;

  // Reference view of each register, built bit by bit from the sources.
  function automatic logic [7:0] model(input logic [7:0]  a,
                                       input logic [17:0] s);
    case (a)
      8'h3C:   model = {s[0], s[1], 6'h00};
      8'h40:   model = {s[2], s[3], s[4], s[5], 4'h0};
      8'h41:   model = {s[6], s[7], s[8], s[9], 3'h0, s[10]};
      8'h42:   model = {4'h0, s[11], s[12], s[13], 1'b0};
      8'h43:   model = {s[14], s[15], s[16], s[17], 4'h0};
      default: model = 8'h00;
    endcase
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Sources are held two edges so the bank has surely sampled them.
  task automatic set_src(input logic [17:0] v);
    src = v;
    acc = acc | v;
    repeat (2) @(posedge clock);
    #1;
  endtask

  // Read strobe stays up, so consecutive calls give back-to-back reads.
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic h);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1;
    chk(reg_rdata, e);
    chk({7'h00, reg_hit}, {7'h00, h});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
  endtask

  // Drops both strobes; read data must not linger past its one cycle.
  task automatic idle;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    @(posedge clock);
    #1;
    chk(reg_rdata, 8'h00);
    chk({7'h00, reg_hit}, 8'h00);
  endtask

  task automatic read_all;
    foreach (addr_q[j])
      rd(addr_q[j], model(addr_q[j], src), 1'b1);
    idle;
  endtask

  // Watchdog so a stuck run still reaches the verdict.
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    test_done;
  end

  // Main sequence.
  initial
  begin
    clock = 1'b0; rst_n = 1'b0; src = '0; acc = '0;
    reg_rd = 1'b0; reg_wr = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    failures = 0; num_checks = 0; seed = 2764;
    addr_q = '{8'h3C, 8'h40, 8'h41, 8'h42, 8'h43};
    repeat (12) @(posedge clock);
    #1 rst_n = 1'b1;
    idle;
    foreach (addr_q[j])
      rd(addr_q[j], 8'h00, 1'b1);
    idle;
    $display("Test reset values done");
    for (int i = 0; i < 18; i++)
    begin
      set_src(18'h1 << i);
      read_all;
    end
    $display("Test walking source done");
    foreach (addr_q[j])
      rd(addr_q[j] ^ 8'h80, 8'h00, 1'b0);
    rd(8'h3D, 8'h00, 1'b0);
    idle;
    $display("Test unmapped reads done");
    for (int k = 0; k < 40; k++)
    begin
      r = $random(seed);
      set_src(r[17:0]);
      // Writes keep reserved positions at zero, as the host must.
      foreach (addr_q[j])
        wr(addr_q[j], 8'($random(seed)) & model(addr_q[j], '1));
      idle;
      read_all;
    end
    $display("Test random writes done");
    rd(8'h3A, model(8'h42, acc), 1'b1);
    rd(8'h3A, model(8'h42, src), 1'b1);
    rd(8'h3B, model(8'h43, acc), 1'b1);
    idle;
    read_all;
    $display("Test latched independence done");
    set_src(18'h3FFFF);
    rst_n = 1'b0;
    acc = '0;
    rd(8'h3C, 8'h00, 1'b0);
    rd(8'h43, 8'h00, 1'b0);
    rst_n = 1'b1;
    idle;
    read_all;
    $display("Test mid-run reset done");
    test_done;
  end
endmodule
`default_nettype wire
